// [include/dsrc_pkg.sv]
package dsrc_pkg;
   // register word offsets (byte addresses on the wishbone bus)
   localparam logic [4:0] OFS_MODE_WR   = 5'h00;
   localparam logic [4:0] OFS_FREQ_RAM  = 5'h04;
   localparam logic [4:0] OFS_FREQ_NV   = 5'h08;
   localparam logic [4:0] OFS_ALM_KEY   = 5'h0c;
   localparam logic [4:0] OFS_PRM_KEY   = 5'h10;
   localparam logic [4:0] OFS_RUN_BITS  = 5'h14;
   localparam logic [4:0] OFS_RUN_EN    = 5'h18;
   localparam logic [4:0] OFS_ACC_ERR   = 5'h1c;

   // command and done bit positions in the command/done words
   localparam int CMD_MODE     = 0;
   localparam int CMD_FREQ_RAM = 1;
   localparam int CMD_FREQ_NV  = 2;
   localparam int CMD_ALM_CLR  = 3;
   localparam int CMD_PRM_CLR  = 4;
   localparam int NUM_CMD      = 5;

   // data codes
   localparam logic [15:0] MODE_NET      = 16'h0000;
   localparam logic [15:0] MODE_EXT      = 16'h0001;
   localparam logic [15:0] MODE_PANEL    = 16'h0002;
   localparam logic [15:0] ERR_ACCESS    = 16'hffff;
   localparam logic [15:0] ERR_NONE      = 16'h0000;
   localparam logic [15:0] ERR_PARAM_BASE = 16'h8000;
   localparam logic [15:0] FREQ_MAX      = 16'd12000;
   localparam logic [15:0] KEY_ALM_CLR   = 16'h9696;
   localparam logic [15:0] KEY_ALL_KEEP  = 16'h9696;
   localparam logic [15:0] KEY_ALL_TERM  = 16'h9966;
   localparam logic [15:0] KEY_NOCOM_KEEP = 16'h5a5a;
   localparam logic [15:0] KEY_NOCOM_TERM = 16'h55aa;
   localparam logic [7:0]  FUNC_SEQ_RUN  = 8'd50;
   localparam logic [11:0] RUN_BITS_MASK = 12'hfff;
   localparam logic [15:0] RESET_VALUE   = 16'h0000;

   // operation modes held by the drive
   typedef enum logic [1:0] {
      DSRC_OP_NET   = 2'b00,
      DSRC_OP_EXT   = 2'b01,
      DSRC_OP_PANEL = 2'b10
   } dsrc_mode_t;

   // parameter clear request toward the parameter store
   typedef struct packed {
      logic valid;
      logic clr_comm;
      logic clr_term;
   } dsrc_prm_clr_t;

   // write request toward a set-frequency store
   typedef struct packed {
      logic        valid;
      logic [15:0] value;
   } dsrc_freq_wr_t;
endpackage

// [design/dsrc_top.sv]
// Overview of operation
// - mode codes 0..2 accepted, else FFFFh error
// - good mode change: done bit, error zero
// - failed mode write keeps current mode
// - nonzero mode selection parameter freezes mode
// - volatile frequency register loads RAM set frequency
// - frequency above 12000 posts FFFFh, unchanged
// - good frequency write: done bit, error zero
// - nonvolatile frequency write, same unit and checks
// - key 9696h erases whole alarm history
// - alarm clear done zeroes error; bad key FFFFh
// - 9696h/9966h clear all; 9966h also terminals
// - 5A5Ah/55AAh spare comm; 55AAh clears terminals
// - reset selection parameter 75 never cleared
// - parameter clear done zero; bad key FFFFh
// - run bits 0..11 are virtual inputs, reset zero
// - sequence-run function 50 not assignable to run bits
// - enabled run bit overrides terminal and network input
// - override only in external or network mode
// - failed parameter write posts number plus 8000h
// - disabled or out-of-range write posts error code
// - act only on command rising edge, done completes
//
// Our own choices: the register offsets and the Wishbone register port.
module dsrc_top #(
   parameter int RUN_BITS = 12
) (
   // clock and reset
   input  wire logic                   SYS_CLK,
   input  wire logic                   RESET,
   input  wire logic                   CLK_EN,
   // wishbone slave
   input  wire logic                   WB_CYC_I,
   input  wire logic                   WB_STB_I,
   input  wire logic                   WB_WE_I,
   input  wire logic [4:0]             WB_ADR_I,
   input  wire logic [3:0]             WB_SEL_I,
   input  wire logic [31:0]            WB_DAT_I,
   output logic      [31:0]            WB_DAT_O,
   output logic                        WB_ACK_O,
   // command strobes from the sequence program and their completions
   input  wire logic [4:0]             CMD_IN,
   output logic      [4:0]             DONE_OUT,
   // drive state inputs
   input  wire logic                   MOTOR_RUNNING,
   input  wire logic [15:0]            MODE_SEL_PARAM,
   input  wire logic [15:0]            PARAM_FAIL_NUM,
   input  wire logic                   PARAM_FAIL,
   input  wire logic [RUN_BITS-1:0]    TERMINAL_IN,
   input  wire logic [RUN_BITS-1:0]    NETWORK_IN,
   input  wire logic [RUN_BITS*8-1:0]  INPUT_FUNC_PARAMS,
   // drive side results
   output logic      [1:0]             OP_MODE,
   output logic      [15:0]            SET_FREQ_RAM,
   output logic      [15:0]            NV_FREQ_DATA,
   output logic                        NV_FREQ_WRITE,
   output logic                        ALARM_HIST_CLEAR,
   output logic                        PRM_CLR_VALID,
   output logic                        PRM_CLR_COMM,
   output logic                        PRM_CLR_TERM,
   output logic      [RUN_BITS-1:0]    EFFECTIVE_IN,
   output logic      [RUN_BITS-1:0]    FUNC_ALLOWED
);

   // registers
   logic [15:0]         mode_wr_ff;
   logic [15:0]         freq_ram_ff;
   logic [15:0]         freq_nv_ff;
   logic [15:0]         alm_key_ff;
   logic [15:0]         prm_key_ff;
   logic [15:0]         run_bits_ff;
   logic [15:0]         run_en_ff;
   logic [15:0]         acc_err_ff;
   dsrc_pkg::dsrc_mode_t mode_ff;
   logic [15:0]         set_freq_ff;
   logic [15:0]         nv_freq_ff;
   logic                nv_wr_ff;
   logic                alm_clr_ff;
   dsrc_pkg::dsrc_prm_clr_t prm_clr_ff;
   logic [4:0]          cmd_s1_ff;
   logic [4:0]          cmd_s2_ff;
   logic [4:0]          cmd_d_ff;
   logic [4:0]          done_ff;
   logic                ack_ff;
   logic [31:0]         rdata_ff;
   logic                run_s1_ff;
   logic                run_s2_ff;
   logic                pfail_s1_ff;
   logic                pfail_s2_ff;
   logic [RUN_BITS-1:0] term_s1_ff;
   logic [RUN_BITS-1:0] term_s2_ff;
   logic [RUN_BITS-1:0] net_s1_ff;
   logic [RUN_BITS-1:0] net_s2_ff;
   logic [RUN_BITS-1:0] eff_ff;

   // combinational helpers
   logic [4:0]  rise;
   logic        wr_req;
   logic        fix_mode;
   logic        mode_ok;
   logic        ram_ok;
   logic        nv_ok;
   logic        alm_ok;
   logic        prm_ok;
   logic        any_err;
   logic        any_ok;
   logic        param_err;
   logic [15:0] nxt_acc_err;

   // a word from the bus is a 16-bit register in the low half, bytes 0 and 1
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = d[7:0];
      end
      if (sel[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   // any of the four parameter-clear keys
   function automatic logic is_prm_key(input logic [15:0] k);
      return (k == dsrc_pkg::KEY_ALL_KEEP) || (k == dsrc_pkg::KEY_ALL_TERM) ||
             (k == dsrc_pkg::KEY_NOCOM_KEEP) || (k == dsrc_pkg::KEY_NOCOM_TERM);
   endfunction

   // asynchronous pins pass two flops before any logic reads them
   // both stages reset low, so no false command edge follows reset
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         cmd_s1_ff   <= '0;
         cmd_s2_ff   <= '0;
         run_s1_ff   <= 1'b0;
         run_s2_ff   <= 1'b0;
         pfail_s1_ff <= 1'b0;
         pfail_s2_ff <= 1'b0;
         term_s1_ff  <= '0;
         term_s2_ff  <= '0;
         net_s1_ff   <= '0;
         net_s2_ff   <= '0;
      end else if (CLK_EN) begin
         cmd_s1_ff   <= CMD_IN;
         cmd_s2_ff   <= cmd_s1_ff;
         run_s1_ff   <= MOTOR_RUNNING;
         run_s2_ff   <= run_s1_ff;
         pfail_s1_ff <= PARAM_FAIL;
         pfail_s2_ff <= pfail_s1_ff;
         term_s1_ff  <= TERMINAL_IN;
         term_s2_ff  <= term_s1_ff;
         net_s1_ff   <= NETWORK_IN;
         net_s2_ff   <= net_s1_ff;
      end
   end

   // only a low-to-high command transition starts a transaction
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         cmd_d_ff <= '0;
      end else if (CLK_EN) begin
         cmd_d_ff <= cmd_s2_ff;
      end
   end
   assign rise     = cmd_s2_ff & ~cmd_d_ff;
   // the mode selection parameter is a same-clock level and is read directly
   assign fix_mode = (MODE_SEL_PARAM != 16'h0000);

   // validity of each command; a running motor refuses mode, alarm and parameter work
   assign mode_ok = !fix_mode && !run_s2_ff && (mode_wr_ff <= dsrc_pkg::MODE_PANEL);
   assign ram_ok  = (freq_ram_ff <= dsrc_pkg::FREQ_MAX);
   assign nv_ok   = (freq_nv_ff <= dsrc_pkg::FREQ_MAX);
   assign alm_ok  = !run_s2_ff && (alm_key_ff == dsrc_pkg::KEY_ALM_CLR);
   assign prm_ok  = !run_s2_ff && is_prm_key(prm_key_ff);

   // two commands rising together may yield a success and a failure at once
   assign any_ok  = (rise[dsrc_pkg::CMD_MODE] && mode_ok) ||
                    (rise[dsrc_pkg::CMD_FREQ_RAM] && ram_ok) ||
                    (rise[dsrc_pkg::CMD_FREQ_NV] && nv_ok) ||
                    (rise[dsrc_pkg::CMD_ALM_CLR] && alm_ok) ||
                    (rise[dsrc_pkg::CMD_PRM_CLR] && prm_ok);
   assign any_err = (rise[dsrc_pkg::CMD_MODE] && !mode_ok) ||
                    (rise[dsrc_pkg::CMD_FREQ_RAM] && !ram_ok) ||
                    (rise[dsrc_pkg::CMD_FREQ_NV] && !nv_ok) ||
                    (rise[dsrc_pkg::CMD_ALM_CLR] && !alm_ok) ||
                    (rise[dsrc_pkg::CMD_PRM_CLR] && !prm_ok);

   // a failed parameter write is reported from outside, through the synchroniser
   assign param_err = pfail_s2_ff;

   // error code; a failure outranks a success landing in the same cycle
   always_comb begin
      nxt_acc_err = acc_err_ff;
      if (any_ok) begin
         nxt_acc_err = dsrc_pkg::ERR_NONE;
      end
      if (param_err) begin
         nxt_acc_err = dsrc_pkg::ERR_PARAM_BASE + PARAM_FAIL_NUM;
      end
      if (any_err) begin
         nxt_acc_err = dsrc_pkg::ERR_ACCESS;
      end
   end

   // completion bits: set on the edge, cleared once the command falls
   // a fresh rise wins over the clear term in the same cycle
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         done_ff <= '0;
      end else if (CLK_EN) begin
         done_ff <= (done_ff & cmd_s2_ff) | rise;
      end
   end

   // operation mode changes only on a valid, unfrozen write
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         mode_ff <= dsrc_pkg::DSRC_OP_NET;
      end else if (CLK_EN && rise[dsrc_pkg::CMD_MODE] && mode_ok) begin
         mode_ff <= dsrc_pkg::dsrc_mode_t'(mode_wr_ff[1:0]);
      end
   end

   // volatile set frequency
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         set_freq_ff <= dsrc_pkg::RESET_VALUE;
      end else if (CLK_EN && rise[dsrc_pkg::CMD_FREQ_RAM] && ram_ok) begin
         set_freq_ff <= freq_ram_ff;
      end
   end

   // non-volatile set frequency: one-cycle store strobe to the eeprom writer
   // one strobe per accepted write only, since every store wears the eeprom
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         nv_freq_ff <= dsrc_pkg::RESET_VALUE;
         nv_wr_ff   <= 1'b0;
      end else if (CLK_EN) begin
         nv_wr_ff <= rise[dsrc_pkg::CMD_FREQ_NV] && nv_ok;
         if (rise[dsrc_pkg::CMD_FREQ_NV] && nv_ok) begin
            nv_freq_ff <= freq_nv_ff;
         end
      end
   end

   // alarm history and parameter clear strobes
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         alm_clr_ff <= 1'b0;
         prm_clr_ff <= '0;
      end else if (CLK_EN) begin
         alm_clr_ff       <= rise[dsrc_pkg::CMD_ALM_CLR] && alm_ok;
         prm_clr_ff.valid <= rise[dsrc_pkg::CMD_PRM_CLR] && prm_ok;
         // parameter 75 is never in the cleared set; the store honours that
         prm_clr_ff.clr_comm <= (prm_key_ff == dsrc_pkg::KEY_ALL_KEEP) ||
                                (prm_key_ff == dsrc_pkg::KEY_ALL_TERM);
         prm_clr_ff.clr_term <= (prm_key_ff == dsrc_pkg::KEY_ALL_TERM) ||
                                (prm_key_ff == dsrc_pkg::KEY_NOCOM_TERM);
      end
   end

   // run-control override per bit, only outside panel mode
   // a bit given the sequence-run function reads low rather than pass through
   genvar gi;
   generate
      for (gi = 0; gi < RUN_BITS; gi++) begin : g_run
         logic allowed;
         assign allowed = (INPUT_FUNC_PARAMS[gi*8 +: 8] != dsrc_pkg::FUNC_SEQ_RUN);
         assign FUNC_ALLOWED[gi] = allowed;
         always_ff @(posedge SYS_CLK) begin
            if (RESET) begin
               eff_ff[gi] <= 1'b0;
            end else if (CLK_EN) begin
               if (run_en_ff[gi] && (mode_ff != dsrc_pkg::DSRC_OP_PANEL)) begin
                  eff_ff[gi] <= run_bits_ff[gi] && allowed;
               end else begin
                  eff_ff[gi] <= term_s2_ff[gi] | net_s2_ff[gi];
               end
            end
         end
      end
   endgenerate

   // wishbone: one-cycle wait then ack, dropped the cycle after;
   // a write lands at the edge that sees ack high, the same edge at which
   // the master takes the answer and releases the request
   assign wr_req = WB_CYC_I && WB_STB_I && WB_WE_I && ack_ff;
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         ack_ff <= 1'b0;
      end else if (CLK_EN) begin
         ack_ff <= WB_CYC_I && WB_STB_I && !ack_ff;
      end
   end

   // register writes; the error register lets hardware win over software
   // keys stay as written, so each new command rise re-checks the same key
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         mode_wr_ff  <= dsrc_pkg::RESET_VALUE;
         freq_ram_ff <= dsrc_pkg::RESET_VALUE;
         freq_nv_ff  <= dsrc_pkg::RESET_VALUE;
         alm_key_ff  <= dsrc_pkg::RESET_VALUE;
         prm_key_ff  <= dsrc_pkg::RESET_VALUE;
         run_bits_ff <= dsrc_pkg::RESET_VALUE;
         run_en_ff   <= dsrc_pkg::RESET_VALUE;
         acc_err_ff  <= dsrc_pkg::RESET_VALUE;
      end else if (CLK_EN) begin
         acc_err_ff <= nxt_acc_err;
         if (wr_req) begin
            unique case (WB_ADR_I)
               dsrc_pkg::OFS_MODE_WR:  mode_wr_ff  <= merge16(mode_wr_ff, WB_DAT_I, WB_SEL_I);
               dsrc_pkg::OFS_FREQ_RAM: freq_ram_ff <= merge16(freq_ram_ff, WB_DAT_I, WB_SEL_I);
               dsrc_pkg::OFS_FREQ_NV:  freq_nv_ff  <= merge16(freq_nv_ff, WB_DAT_I, WB_SEL_I);
               dsrc_pkg::OFS_ALM_KEY:  alm_key_ff  <= merge16(alm_key_ff, WB_DAT_I, WB_SEL_I);
               dsrc_pkg::OFS_PRM_KEY:  prm_key_ff  <= merge16(prm_key_ff, WB_DAT_I, WB_SEL_I);
               dsrc_pkg::OFS_RUN_BITS: run_bits_ff <=
                  merge16(run_bits_ff, WB_DAT_I, WB_SEL_I) & {4'h0, dsrc_pkg::RUN_BITS_MASK};
               dsrc_pkg::OFS_RUN_EN:   run_en_ff   <=
                  merge16(run_en_ff, WB_DAT_I, WB_SEL_I) & {4'h0, dsrc_pkg::RUN_BITS_MASK};
               dsrc_pkg::OFS_ACC_ERR: begin
                  if (!any_ok && !any_err && !param_err) begin
                     acc_err_ff <= merge16(acc_err_ff, WB_DAT_I, WB_SEL_I);
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // read data is registered; unmapped addresses read zero
   // the address is sampled every cycle, so data stands while ack is high
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         rdata_ff <= '0;
      end else if (CLK_EN) begin
         unique case (WB_ADR_I)
            dsrc_pkg::OFS_MODE_WR:  rdata_ff <= {16'h0000, mode_wr_ff};
            dsrc_pkg::OFS_FREQ_RAM: rdata_ff <= {16'h0000, freq_ram_ff};
            dsrc_pkg::OFS_FREQ_NV:  rdata_ff <= {16'h0000, freq_nv_ff};
            dsrc_pkg::OFS_ALM_KEY:  rdata_ff <= {16'h0000, alm_key_ff};
            dsrc_pkg::OFS_PRM_KEY:  rdata_ff <= {16'h0000, prm_key_ff};
            dsrc_pkg::OFS_RUN_BITS: rdata_ff <= {16'h0000, run_bits_ff};
            dsrc_pkg::OFS_RUN_EN:   rdata_ff <= {16'h0000, run_en_ff};
            dsrc_pkg::OFS_ACC_ERR:  rdata_ff <= {16'h0000, acc_err_ff};
            default:                rdata_ff <= '0;
         endcase
      end
   end

   // outputs
   // all but the function mask come straight from flip-flops
   assign WB_ACK_O         = ack_ff;
   assign WB_DAT_O         = rdata_ff;
   assign DONE_OUT         = done_ff;
   assign OP_MODE          = mode_ff;
   assign SET_FREQ_RAM     = set_freq_ff;
   assign NV_FREQ_DATA     = nv_freq_ff;
   assign NV_FREQ_WRITE    = nv_wr_ff;
   assign ALARM_HIST_CLEAR = alm_clr_ff;
   assign PRM_CLR_VALID    = prm_clr_ff.valid;
   assign PRM_CLR_COMM     = prm_clr_ff.clr_comm;
   assign PRM_CLR_TERM     = prm_clr_ff.clr_term;
   assign EFFECTIVE_IN     = eff_ff;

endmodule

// [dv/dsrc_top_assertions.sv]
module dsrc_chk #(
   parameter int RUN_BITS = 12
) (
   // clock and reset
   input wire logic                  SYS_CLK,
   input wire logic                  RESET,
   // watched ports
   input wire logic                  WB_ACK_O,
   input wire logic [4:0]            CMD_IN,
   input wire logic [4:0]            DONE_OUT,
   input wire logic [15:0]           MODE_SEL_PARAM,
   input wire logic [RUN_BITS*8-1:0] INPUT_FUNC_PARAMS,
   input wire logic [1:0]            OP_MODE,
   input wire logic [15:0]           SET_FREQ_RAM,
   input wire logic [15:0]           NV_FREQ_DATA,
   input wire logic                  NV_FREQ_WRITE,
   input wire logic                  ALARM_HIST_CLEAR,
   input wire logic                  PRM_CLR_VALID,
   input wire logic [RUN_BITS-1:0]   FUNC_ALLOWED
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   // a completion may only rise after its command has passed the synchroniser
   a_done_after_cmd: assert property (
      (DONE_OUT & ~$past(DONE_OUT) & ~$past(CMD_IN, 2)) == 5'h00) else $error("done without cmd");
   a_done_release: assert property (
      $fell(CMD_IN[0]) |-> ##[1:6] !DONE_OUT[0]) else $error("done stuck after cmd low");
   a_mode_cause: assert property (
      $changed(OP_MODE) |-> $rose(DONE_OUT[0])) else $error("mode changed without done");
   a_mode_frozen: assert property (
      (MODE_SEL_PARAM != 16'h0000 && $past(MODE_SEL_PARAM) != 16'h0000) |-> $stable(OP_MODE))
      else $error("mode moved while frozen");
   a_freq_cause: assert property (
      $changed(SET_FREQ_RAM) |-> $rose(DONE_OUT[1]) && SET_FREQ_RAM <= dsrc_pkg::FREQ_MAX)
      else $error("bad ram frequency update");
   a_nv_pulse: assert property (
      NV_FREQ_WRITE |-> ($rose(DONE_OUT[2]) && NV_FREQ_DATA <= dsrc_pkg::FREQ_MAX)
      ##1 !NV_FREQ_WRITE) else $error("bad nv frequency write");
   a_alarm_pulse: assert property (
      ALARM_HIST_CLEAR |-> $rose(DONE_OUT[3]) ##1 !ALARM_HIST_CLEAR) else $error("bad alarm clear");
   a_prm_pulse: assert property (
      PRM_CLR_VALID |-> $rose(DONE_OUT[4]) ##1 !PRM_CLR_VALID) else $error("bad param clear");
   a_ack_pulse: assert property (
      WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
   a_func_block: assert property (
      FUNC_ALLOWED[0] == (INPUT_FUNC_PARAMS[7:0] != dsrc_pkg::FUNC_SEQ_RUN))
      else $error("sequence run function allowed");
endmodule
bind dsrc_top dsrc_chk #(.RUN_BITS(RUN_BITS)) u_chk (.SYS_CLK(SYS_CLK), .RESET(RESET),
   .WB_ACK_O(WB_ACK_O), .CMD_IN(CMD_IN), .DONE_OUT(DONE_OUT), .MODE_SEL_PARAM(MODE_SEL_PARAM),
   .INPUT_FUNC_PARAMS(INPUT_FUNC_PARAMS), .OP_MODE(OP_MODE), .SET_FREQ_RAM(SET_FREQ_RAM),
   .NV_FREQ_DATA(NV_FREQ_DATA), .NV_FREQ_WRITE(NV_FREQ_WRITE),
   .ALARM_HIST_CLEAR(ALARM_HIST_CLEAR), .PRM_CLR_VALID(PRM_CLR_VALID),
   .FUNC_ALLOWED(FUNC_ALLOWED));

// [dv/dsrc_seq_model.sv]
module dsrc_seq_model (
   // clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // request from the bench
   input wire logic       go,
   input wire logic [2:0] idx,
   output logic           busy,
   // command and completion bits
   input wire logic [4:0] done,
   output logic [4:0]     cmd
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] st_ff;
   logic [2:0] idx_ff;
   // raise, wait for done, lower, wait for done to clear; a held bit never re-arms
   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= 2'h0;
         cmd <= 5'h00;
         busy <= 1'b0;
         idx_ff <= 3'h0;
      end else begin
         case (st_ff)
            2'h0: if (go) begin
               idx_ff <= idx;
               cmd[idx] <= 1'b1;
               busy <= 1'b1;
               st_ff <= 2'h1;
            end
            2'h1: if (done[idx_ff]) begin
               cmd[idx_ff] <= 1'b0;
               st_ff <= 2'h2;
            end
            2'h2: if (!done[idx_ff]) begin
               busy <= 1'b0;
               st_ff <= 2'h0;
            end
            default: st_ff <= 2'h0;
         endcase
      end
   end
endmodule

// [dv/dsrc_tb_top.sv]
module dsrc_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, cyc, stb, we, ack, motor, pfail, go, busy, nvw, alm, pv, pc, pt;
   logic [4:0] adr, cmd, done;
   logic [31:0] dat, rdat;
   logic [15:0] msel, pnum, fram, nvd;
   logic [11:0] term, netin, eff, fal;
   logic [95:0] func;
   logic [1:0] op_mode, prm_last;
   logic [2:0] idx;
   int fail_count = 0, checked = 0, nv_n = 0, alm_n = 0, prm_n = 0;
   dsrc_top uut (.SYS_CLK(clk), .RESET(rst), .CLK_EN(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(dat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .CMD_IN(cmd), .DONE_OUT(done), .MOTOR_RUNNING(motor),
      .MODE_SEL_PARAM(msel), .PARAM_FAIL_NUM(pnum), .PARAM_FAIL(pfail), .TERMINAL_IN(term),
      .NETWORK_IN(netin), .INPUT_FUNC_PARAMS(func), .OP_MODE(op_mode), .SET_FREQ_RAM(fram),
      .NV_FREQ_DATA(nvd), .NV_FREQ_WRITE(nvw), .ALARM_HIST_CLEAR(alm), .PRM_CLR_VALID(pv),
      .PRM_CLR_COMM(pc), .PRM_CLR_TERM(pt), .EFFECTIVE_IN(eff), .FUNC_ALLOWED(fal));
   dsrc_seq_model u_seq (.clk(clk), .rst(rst), .go(go), .idx(idx), .busy(busy), .done(done),
      .cmd(cmd));
   // count single-cycle strobes so the scenarios can see them after the fact
   always @(posedge clk) begin
      if (nvw === 1'b1) nv_n++;
      if (alm === 1'b1) alm_n++;
      if (pv === 1'b1) begin
         prm_n++;
         prm_last = {pc, pt};
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // classic cycle: hold everything until ack is sampled high, then release
   task automatic wb(input logic w, input logic [4:0] a, input logic [15:0] d,
                     output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {16'h0000, d};
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 16'h0000, q);
      chk(q, e);
   endtask
   // load the data word, pulse the command through the partner, check the error word
   task automatic op(input int i, input logic [4:0] a, input logic [15:0] d,
                     input logic [15:0] err);
      wr(a, d);
      @(posedge clk); go <= 1'b1; idx <= 3'(i);
      @(posedge clk); go <= 1'b0;
      do begin
         @(posedge clk);
      end while (busy !== 1'b0);
      rd_chk(dsrc_pkg::OFS_ACC_ERR, {16'h0000, err});
   endtask
   task automatic t_reset();
      chk(32'(op_mode), 32'h0);
      rd_chk(dsrc_pkg::OFS_RUN_BITS, 32'h0);
      rd_chk(dsrc_pkg::OFS_RUN_EN, 32'h0);
      wr(dsrc_pkg::OFS_ACC_ERR, 16'h1234);
      rd_chk(dsrc_pkg::OFS_ACC_ERR, 32'h1234);
      wr(5'h02, 16'h0002); // unaligned hole: ignored and reads zero
      rd_chk(5'h02, 32'h0);
   endtask
   task automatic t_mode();
      for (int i = 0; i < 3; i++) begin
         op(0, dsrc_pkg::OFS_MODE_WR, 16'(i), dsrc_pkg::ERR_NONE);
         chk(32'(op_mode), 32'(i));
      end
      op(0, dsrc_pkg::OFS_MODE_WR, 16'h0003, dsrc_pkg::ERR_ACCESS);
      chk(32'(op_mode), 32'h2);
      motor <= 1'b1;
      op(0, dsrc_pkg::OFS_MODE_WR, 16'h0000, dsrc_pkg::ERR_ACCESS);
      motor <= 1'b0;
      msel <= 16'h0001;
      op(0, dsrc_pkg::OFS_MODE_WR, 16'h0001, dsrc_pkg::ERR_ACCESS);
      msel <= 16'h0000;
      chk(32'(op_mode), 32'h2);
   endtask
   // frequency traffic only in panel mode; repeated edits go to the ram word
   task automatic t_freq();
      int n0;
      n0 = nv_n;
      op(1, dsrc_pkg::OFS_FREQ_RAM, 16'd12000, dsrc_pkg::ERR_NONE);
      chk(32'(fram), 32'd12000);
      op(1, dsrc_pkg::OFS_FREQ_RAM, 16'd12001, dsrc_pkg::ERR_ACCESS);
      chk(32'(fram), 32'd12000);
      op(2, dsrc_pkg::OFS_FREQ_NV, 16'd6000, dsrc_pkg::ERR_NONE);
      op(2, dsrc_pkg::OFS_FREQ_NV, 16'hffff, dsrc_pkg::ERR_ACCESS);
      chk(32'(nv_n - n0), 32'h1);
      chk(32'(nvd), 32'd6000);
   endtask
   task automatic t_clear();
      logic [15:0] keys [4] = '{16'h9696, 16'h9966, 16'h5a5a, 16'h55aa};
      logic [1:0] ct [4] = '{2'b10, 2'b11, 2'b00, 2'b01};
      int a0, p0;
      a0 = alm_n;
      op(3, dsrc_pkg::OFS_ALM_KEY, 16'h9696, dsrc_pkg::ERR_NONE);
      op(3, dsrc_pkg::OFS_ALM_KEY, 16'h9966, dsrc_pkg::ERR_ACCESS);
      motor <= 1'b1;
      op(3, dsrc_pkg::OFS_ALM_KEY, 16'h9696, dsrc_pkg::ERR_ACCESS);
      op(4, dsrc_pkg::OFS_PRM_KEY, 16'h9696, dsrc_pkg::ERR_ACCESS);
      motor <= 1'b0;
      chk(32'(alm_n - a0), 32'h1);
      for (int i = 0; i < 4; i++) begin
         p0 = prm_n;
         op(4, dsrc_pkg::OFS_PRM_KEY, keys[i], dsrc_pkg::ERR_NONE);
         chk(32'(prm_n - p0), 32'h1);
         chk(32'(prm_last), 32'(ct[i]));
      end
      p0 = prm_n;
      op(4, dsrc_pkg::OFS_PRM_KEY, 16'h1234, dsrc_pkg::ERR_ACCESS);
      chk(32'(prm_n - p0), 32'h0);
   endtask
   task automatic t_run();
      term <= 12'h0a0; netin <= 12'h300;
      wr(dsrc_pkg::OFS_RUN_BITS, 16'h0005);
      wr(dsrc_pkg::OFS_RUN_EN, 16'h0fff);
      op(0, dsrc_pkg::OFS_MODE_WR, dsrc_pkg::MODE_EXT, dsrc_pkg::ERR_NONE);
      repeat (6) @(posedge clk);
      chk(32'(eff), 32'h005);
      func <= {88'h0, 8'd50};
      repeat (6) @(posedge clk);
      chk(32'(fal), 32'hffe);
      chk(32'(eff), 32'h004);
      wr(dsrc_pkg::OFS_RUN_EN, 16'h0000);
      repeat (6) @(posedge clk);
      chk(32'(eff), 32'h3a0);
      wr(dsrc_pkg::OFS_RUN_EN, 16'h0fff);
      op(0, dsrc_pkg::OFS_MODE_WR, dsrc_pkg::MODE_PANEL, dsrc_pkg::ERR_NONE);
      repeat (6) @(posedge clk);
      chk(32'(eff), 32'h3a0);
      op(0, dsrc_pkg::OFS_MODE_WR, dsrc_pkg::MODE_NET, dsrc_pkg::ERR_NONE);
      repeat (6) @(posedge clk);
      chk(32'(eff), 32'h004);
   endtask
   task automatic t_fail();
      pnum <= 16'd10; pfail <= 1'b1;
      repeat (6) @(posedge clk);
      pfail <= 1'b0;
      repeat (6) @(posedge clk);
      rd_chk(dsrc_pkg::OFS_ACC_ERR, 32'h800a);
   endtask
   task automatic stop_test();
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // the whole run needs well under a thousand cycles; this bound only cuts a hang
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      stop_test();
   end
   initial begin
      rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 5'h00; dat = 32'h0; go = 1'b0;
      idx = 3'h0; motor = 1'b0; msel = 16'h0; pnum = 16'h0; pfail = 1'b0; term = 12'h0;
      netin = 12'h0; func = 96'h0; prm_last = 2'h0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_mode();
      t_freq();
      t_clear();
      t_run();
      t_fail();
      stop_test();
   end
endmodule
